// file: core/ocd_pkg.sv
/*
 Constants for the on-screen-display character colour decode: display RAM layout,
 mode codes, colour code field positions and the extended colour table.
 Assumes nothing of its surroundings.
*/
package ocd_pkg;
   localparam int unsigned OCD_BLOCKS = 16;
   localparam int unsigned OCD_CHARS = 40;
   localparam int unsigned OCD_RAM_AW = 11;
   localparam logic [10:0] OCD_BLOCK_STRIDE = 11'h080;
   localparam logic [10:0] OCD_CC1_OFS = 11'h040;
   localparam logic [10:0] OCD_CC2_OFS = 11'h028;
   localparam logic [6:0] OCD_NOACC_LO = 7'h78;
   localparam logic [6:0] OCD_NOACC_HI = 7'h7A;
   localparam logic [7:0] OCD_RAM_RESET = 8'h00;
   // Colour code 1 fields.
   localparam int unsigned C1_HIGH_BIT = 0;
   localparam int unsigned C1_R = 1;
   localparam int unsigned C1_G = 2;
   localparam int unsigned C1_B = 3;
   localparam int unsigned C1_LUM = 4;
   localparam int unsigned C1_FLASH_I = 5;
   localparam int unsigned C1_UNDER = 6;
   localparam int unsigned C1_ITALIC = 7;
   // Colour code 2 fields.
   localparam int unsigned C2_R = 0;
   localparam int unsigned C2_G = 1;
   localparam int unsigned C2_B = 2;
   localparam int unsigned C2_I = 3;
   localparam logic [3:0] C2_STORE_MASK = 4'hF;
   // Block control bits that shape the luminance outputs.
   localparam int unsigned BC_LUM2 = 2;
   localparam int unsigned BC_LUM7 = 7;
   localparam logic [8:0] OCD_EX_CODE = 9'h140;
   typedef enum logic [1:0] {OCD_CC, OCD_OSD, OCD_EXOSD} ocd_mode_e;
   // Extended colour table entries {R,G,B,I1,I2}.
   localparam logic [39:0] OCD_EXT_TABLE = {5'h1C, 5'h0E, 5'h1E, 5'h19,
                                            5'h1A, 5'h08, 5'h10, 5'h00};
endpackage

// file: core/ocd_ram.sv
/*
 Display RAM of flip-flops for the character decode. Byte wide, one write port and
 two read ports. Assumes the host keeps away from the excluded locations.
*/
`timescale 1ns/1ps
module ocd_ram
   import ocd_pkg::*;
#(
   parameter int unsigned AW = 11,
   parameter int unsigned BASE_ADDR = 12'h800
)
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Write port.
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [7:0] i_wdata,
   // Read ports.
   input wire logic [AW-1:0] i_raddr_a,
   output logic [7:0] o_rdata_a,
   input wire logic [AW-1:0] i_raddr_b,
   output logic [7:0] o_rdata_b
);
   logic [7:0] mem_q [2**AW];
   logic [7:0] mem_d [2**AW];

   always_comb
   begin
      mem_d = mem_q;
      if (i_we)
      begin
         mem_d[i_waddr] = i_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < 2**AW; i++)
         begin
            mem_q[i] <= OCD_RAM_RESET;
         end
      end
      else
      begin
         mem_q <= mem_d;
      end
   end

   assign o_rdata_a = mem_q[i_raddr_a];
   assign o_rdata_b = mem_q[i_raddr_b];
endmodule

// file: core/ocd_decode.sv
/*
 Character colour decode for the on-screen display: display RAM, per-character
 attribute fetch, and colour and luminance output for three display modes.
 Assumes a dot timing unit supplies block, column and dot-class inputs in step
 with the clock, and a font unit answers the 9-bit font code with a font dot.
*/
`timescale 1ns/1ps
module ocd_decode
   import ocd_pkg::*;
#(
   parameter int unsigned ROW_W = 5,
   parameter logic [4:0] UNDER_ROW_A = 5'h16,
   parameter logic [4:0] UNDER_ROW_B = 5'h17
)
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Host access to display RAM, offsets within the 0x800-byte area.
   input wire logic i_host_we,
   input wire logic [10:0] i_host_addr,
   input wire logic [7:0] i_host_wdata,
   output logic [7:0] o_host_rdata,
   // Dot timing.
   input wire logic [3:0] i_block,
   input wire logic [5:0] i_column,
   input wire logic [ROW_W-1:0] i_dot_row,
   input wire logic i_display_area,
   input wire logic i_border_dot,
   input wire logic i_extra_dot,
   input wire logic i_flash_phase,
   // Per-block settings.
   input wire logic [1:0] i_block_mode,
   input wire logic [7:0] i_block_ctrl,
   // Font unit.
   input wire logic i_font_dot,
   output logic [8:0] o_font_code,
   output logic [4:0] o_extra_font_code,
   output logic o_italic,
   // Video outputs.
   output logic o_red,
   output logic o_green,
   output logic o_blue,
   output logic o_intensity_out_a,
   output logic o_intensity_out_b,
   output logic o_luminance_ctrl_a,
   output logic o_luminance_ctrl_b
);
   logic [10:0] base;
   logic [10:0] code_addr;
   logic [10:0] c1_addr;
   logic [10:0] c2_addr;
   logic [7:0] code_byte;
   logic [7:0] cc1;
   logic [7:0] cc2_raw;
   logic [7:0] host_raw;
   logic [10:0] host_c2_ofs;
   logic host_is_c2;
   ocd_mode_e mode;
   logic [4:0] fg_rgbii;
   logic [4:0] bg_rgbii;
   logic fg_show;
   logic bg_show;
   logic underline;
   logic [4:0] rgbii_d;
   logic [4:0] rgbii_q;
   logic lum_a_d;
   logic lum_a_q;
   logic lum_b_d;
   logic lum_b_q;
   logic [8:0] font_code_d;
   logic [8:0] font_code_q;
   logic [4:0] extra_d;
   logic [4:0] extra_q;
   logic italic_d;
   logic italic_q;
   logic [2:0] fg_select;
   logic [2:0] bg_select;

   function automatic logic [4:0] ext_colour(input logic [2:0] sel);
      ext_colour = OCD_EXT_TABLE[5*sel +: 5];
   endfunction

   function automatic logic is_c2_addr(input logic [10:0] a);
      logic [6:0] o;
      o = a[6:0];
      is_c2_addr = (o >= OCD_CC2_OFS[6:0]) && (o < OCD_CC1_OFS[6:0])
         || (o >= 7'h68) && (o < 7'h78);
   endfunction

   assign base = 11'(i_block) * OCD_BLOCK_STRIDE;
   // Colour 2 for columns 24 and up sits above the colour 1 run.
   assign code_addr = base + 11'(i_column);
   assign c1_addr = base + OCD_CC1_OFS + 11'(i_column);
   assign c2_addr = base + OCD_CC2_OFS + 11'(i_column)
      + ((i_column >= 6'h18) ? 11'h028 : 11'h000);
   // The host reads through its own port, so a read in the display area is safe.
   // Two copies take every host write; storage is traded for four read ports.

   ocd_ram #(
      .AW(OCD_RAM_AW),
      .BASE_ADDR(12'h800)
   ) u_ram (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_we(i_host_we),
      .i_waddr(i_host_addr),
      .i_wdata(i_host_wdata),
      .i_raddr_a(i_host_addr),
      .o_rdata_a(host_raw),
      .i_raddr_b(c2_addr),
      .o_rdata_b(cc2_raw)
   );

   ocd_ram #(
      .AW(OCD_RAM_AW),
      .BASE_ADDR(12'h800)
   ) u_attr (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_we(i_host_we),
      .i_waddr(i_host_addr),
      .i_wdata(i_host_wdata),
      .i_raddr_a(c1_addr),
      .o_rdata_a(cc1),
      .i_raddr_b(code_addr),
      .o_rdata_b(code_byte)
   );

   assign host_c2_ofs = i_host_addr;
   assign host_is_c2 = is_c2_addr(host_c2_ofs);
   // Colour 2 upper nibble is not meaningful; it reads as zero here.
   assign o_host_rdata = host_is_c2 ? {4'h0, host_raw[3:0] & C2_STORE_MASK}
      : host_raw;
   assign mode = ocd_mode_e'(i_block_mode);
   assign fg_select = {cc1[C1_B], cc1[C1_G], cc1[C1_R]};
   assign bg_select = {cc2_raw[C2_B], cc2_raw[C2_G], cc2_raw[C2_R]};
   assign underline = (mode == OCD_CC) && cc1[C1_UNDER]
      && ((i_dot_row == UNDER_ROW_A) || (i_dot_row == UNDER_ROW_B));
   // Flash blanks font and underline during the off phase only.
   assign fg_show = (i_font_dot || underline)
      && !((mode == OCD_CC) && cc1[C1_FLASH_I] && !i_flash_phase);
   assign bg_show = i_display_area && !i_font_dot && !underline
      && !i_border_dot && !i_extra_dot;

   // Colour group. Font wins over background, which fills only empty area dots.
   always_comb
   begin
      fg_rgbii = 5'h00;
      bg_rgbii = 5'h00;
      unique case (mode)
         OCD_CC:
         begin
            fg_rgbii = {cc1[C1_R], cc1[C1_G], cc1[C1_B], 2'b00};
            bg_rgbii = {cc2_raw[C2_R], cc2_raw[C2_G], cc2_raw[C2_B], 2'b00};
         end
         OCD_OSD:
         begin
            fg_rgbii = {cc1[C1_R], cc1[C1_G], cc1[C1_B], cc1[C1_FLASH_I], 1'b0};
            bg_rgbii = {cc2_raw[C2_R], cc2_raw[C2_G], cc2_raw[C2_B],
               cc2_raw[C2_I], 1'b0};
         end
         OCD_EXOSD:
         begin
            fg_rgbii = ext_colour(fg_select);
            bg_rgbii = ext_colour(bg_select);
         end
         default:
         begin
            fg_rgbii = 5'h00;
            bg_rgbii = 5'h00;
         end
      endcase
      if (!i_display_area)
      begin
         rgbii_d = 5'h00;
      end
      else if (fg_show)
      begin
         rgbii_d = fg_rgbii;
      end
      else if (bg_show)
      begin
         rgbii_d = bg_rgbii;
      end
      else
      begin
         rgbii_d = 5'h00;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rgbii_q <= 5'h00;
      end
      else
      begin
         rgbii_q <= rgbii_d;
      end
   end

   // Luminance group. Mode reaches it only through fg_show, where caption underline and flash change the keying.
   always_comb
   begin
      // Block bit 7 widens luminance A to the whole area; bit 2 passes the character's luminance bit to B.
      if (!i_display_area)
      begin
         lum_a_d = 1'b0;
         lum_b_d = 1'b0;
      end
      else
      begin
         lum_a_d = (cc1[C1_LUM] || i_block_ctrl[BC_LUM7]) ? 1'b1 : fg_show;
         lum_b_d = i_block_ctrl[BC_LUM2] && cc1[C1_LUM];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lum_a_q <= 1'b0;
         lum_b_q <= 1'b0;
      end
      else
      begin
         lum_a_q <= lum_a_d;
         lum_b_q <= lum_b_d;
      end
   end

   // Font code group. The fetch has its own read port, so host traffic cannot bend it.
   always_comb
   begin
      font_code_d = {cc1[C1_HIGH_BIT], code_byte};
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         font_code_q <= 9'h000;
      end
      else
      begin
         font_code_q <= font_code_d;
      end
   end

   // Attribute group: extra font code and italic request for the font unit.
   always_comb
   begin
      extra_d = 5'h00;
      if (mode == OCD_EXOSD)
      begin
         extra_d = {(font_code_d == OCD_EX_CODE), cc2_raw[C2_I], cc1[7:5]};
      end
      italic_d = (mode == OCD_CC) && cc1[C1_ITALIC];
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         extra_q <= 5'h00;
         italic_q <= 1'b0;
      end
      else
      begin
         extra_q <= extra_d;
         italic_q <= italic_d;
      end
   end

   assign o_red = rgbii_q[4];
   assign o_green = rgbii_q[3];
   assign o_blue = rgbii_q[2];
   assign o_intensity_out_a = rgbii_q[1];
   assign o_intensity_out_b = rgbii_q[0];
   assign o_luminance_ctrl_a = lum_a_q;
   assign o_luminance_ctrl_b = lum_b_q;
   assign o_font_code = font_code_q;
   assign o_extra_font_code = extra_q;
   assign o_italic = italic_q;
endmodule

// file: verification/ocd_decode_props.sv
/* Port assertions for the character colour decode.
 Assumes it is bound to ocd_decode and that the block has one clock domain. */
`timescale 1ns/1ps
module ocd_decode_props
   import ocd_pkg::*;
(
   // Clock, reset and dot inputs.
   input wire logic i_clock, i_rst_n, i_host_we, i_display_area, i_border_dot, i_extra_dot,
   input wire logic i_font_dot,
   input wire logic [3:0] i_block,
   input wire logic [5:0] i_column,
   input wire logic [1:0] i_block_mode,
   input wire logic [7:0] i_block_ctrl,
   // Outputs watched.
   input wire logic [8:0] o_font_code,
   input wire logic o_italic, o_red, o_green, o_blue, o_intensity_out_a, o_intensity_out_b,
   input wire logic o_luminance_ctrl_a, o_luminance_ctrl_b
);
   logic [4:0] col;
   logic quiet;
   assign col = {o_red, o_green, o_blue, o_intensity_out_a, o_intensity_out_b};
   assign quiet = !i_border_dot && !i_extra_dot;
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   property p_blank; !(i_display_area || i_font_dot) && quiet |=> col == 5'h00;
   endproperty
   a_blank: assert property (p_blank) else $error("colour on an empty dot");
   property p_off_mode; i_block_mode == 2'h3 && quiet |=> col == 5'h00;
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("colour in off mode");
   property p_ext_table; i_block_mode == OCD_EXOSD && quiet |=>
      col inside {5'h00, 5'h10, 5'h08, 5'h1A, 5'h19, 5'h1E, 5'h0E, 5'h1C};
   endproperty
   a_ext_table: assert property (p_ext_table) else $error("colour not in table");
   property p_lum_area; i_display_area && i_block_ctrl[7] && i_block_mode != 2'h3 |=>
      o_luminance_ctrl_a;
   endproperty
   a_lum_area: assert property (p_lum_area) else $error("luminance a low in area");
   property p_lum_b; o_luminance_ctrl_b |-> $past(i_block_ctrl[2]);
   endproperty
   a_lum_b: assert property (p_lum_b) else $error("luminance b without block bit");
   property p_italic; o_italic |-> $past(i_block_mode) == OCD_CC;
   endproperty
   a_italic: assert property (p_italic) else $error("italic outside caption mode");
   property p_i2; o_intensity_out_b |-> $past(i_block_mode) == OCD_EXOSD || $past(i_border_dot);
   endproperty
   a_i2: assert property (p_i2) else $error("second intensity outside extended mode");
   property p_code_hold; $stable(i_block) && $stable(i_column) && !$past(i_host_we) |=>
      $stable(o_font_code);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("font code moved");
endmodule
bind ocd_decode ocd_decode_props i_ocd_decode_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_host_we(i_host_we), .i_display_area(i_display_area), .i_border_dot(i_border_dot),
   .i_extra_dot(i_extra_dot), .i_font_dot(i_font_dot), .i_block(i_block), .i_column(i_column),
   .i_block_mode(i_block_mode), .i_block_ctrl(i_block_ctrl), .o_font_code(o_font_code),
   .o_italic(o_italic), .o_red(o_red), .o_green(o_green), .o_blue(o_blue),
   .o_intensity_out_a(o_intensity_out_a), .o_intensity_out_b(o_intensity_out_b),
   .o_luminance_ctrl_a(o_luminance_ctrl_a), .o_luminance_ctrl_b(o_luminance_ctrl_b));

// file: verification/ocd_monitor.sv
/* Video monitor model: the colour, intensity and luminance lines as the set sees them.
 Assumes the lines are registered outputs of the decode. */
`timescale 1ns/1ps
module ocd_monitor
(
   // Lines from the decode.
   input wire logic [6:0] i_video,
   // What the set shows.
   output logic [6:0] o_seen
);
   // No storage, so the bench judges the same dot that the decode produced.
   assign o_seen = i_video;
endmodule

// file: verification/ocd_decode_tb.sv
/* Bench for the character colour decode: random characters, modes and dots.
 Assumes the monitor model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module ocd_decode_tb
   import ocd_pkg::*;
   ;
   typedef struct {logic [21:0] v; logic [2:0] care;} ocd_note_s;
   localparam logic [4:0] TBL [8] = '{5'h00, 5'h10, 5'h08, 5'h1A, 5'h19, 5'h1E, 5'h0E, 5'h1C};
   logic clock = 1'b0, rst_n = 1'b0, we = 1'b0, area = 1'b0, bdot = 1'b0, xdot = 1'b0;
   logic fdot = 1'b0, fph = 1'b0, rq = 1'b0, pq = 1'b0, p1 = 1'b0, ital;
   logic [10:0] addr = 11'h000;
   logic [7:0] wdata = 8'h00, ctrl = 8'h00, rdata;
   logic [5:0] col = 6'h00;
   logic [4:0] row = 5'h00, xcode;
   logic [3:0] blk = 4'h0;
   logic [1:0] mode = 2'h0;
   logic [8:0] fcode;
   logic [6:0] video, seen;
   ocd_note_s notes[$];
   ocd_note_s nt;
   int num_errors = 0, checks_done = 0;
   always #50 clock = ~clock;
   ocd_decode i_ocd_decode (.i_clock(clock), .i_rst_n(rst_n), .i_host_we(we), .i_host_addr(addr),
      .i_host_wdata(wdata), .o_host_rdata(rdata), .i_block(blk), .i_column(col), .i_dot_row(row),
      .i_display_area(area), .i_border_dot(bdot), .i_extra_dot(xdot), .i_flash_phase(fph),
      .i_block_mode(mode), .i_block_ctrl(ctrl), .i_font_dot(fdot), .o_font_code(fcode),
      .o_extra_font_code(xcode), .o_italic(ital), .o_red(video[6]), .o_green(video[5]),
      .o_blue(video[4]), .o_intensity_out_a(video[3]), .o_intensity_out_b(video[2]),
      .o_luminance_ctrl_a(video[1]), .o_luminance_ctrl_b(video[0]));
   ocd_monitor i_ocd_monitor (.i_video(video), .o_seen(seen));
   task automatic chk(input string name, input logic [8:0] e, input logic [8:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clock);
      {we, rq, pq, addr, wdata} = {3'b100, a, d};
   endtask
   // Reads use the host's own port, though the task still drives the display area low for each read.
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(negedge clock);
      {we, area, pq, rq, addr} = {4'b0001, a};
      notes.push_back('{{14'h0000, e}, 3'h0});
   endtask
   always @(posedge clock)
   begin
      p1 <= pq;
      if (p1)
      begin
         nt = notes.pop_front();
         chk("font_code", nt.v[21:13], fcode);
         if (nt.care[2]) chk("colour", {4'h0, nt.v[12:8]}, {4'h0, seen[6:2]});
         if (nt.care[1]) chk("luminance", {7'h00, nt.v[7:6]}, {7'h00, seen[1:0]});
         chk("italic", {8'h00, nt.v[5]}, {8'h00, ital});
         if (nt.care[0]) chk("extra_code", {4'h0, nt.v[4:0]}, {4'h0, xcode});
      end
      if (rq)
      begin
         nt = notes.pop_front();
         chk("host_rdata", {1'b0, nt.v[7:0]}, {1'b0, rdata});
      end
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      test_done();
   end
   initial
   begin : main
      logic [7:0] ch, c1, c2;
      logic [10:0] base, a2;
      logic [5:0] c;
      logic [31:0] r;
      logic u, fg, hide;
      logic [4:0] ec;
      ocd_note_s n;
      void'($urandom(32'h3A43));
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 400; i++)
      begin
         r = $urandom;
         c = 6'($urandom % 40);
         {c2, c1, ch} = r[23:0];
         if (i % 8 == 0)
            {c1[0], ch} = 9'h140;
         base = {r[27:24], 7'h00};
         // Columns stop at 39, so the excluded offsets are never touched.
         a2 = base + 11'h028 + {5'h00, c} + (c > 6'h17 ? 11'h028 : 11'h000);
         wr(base + {5'h00, c}, ch);
         wr(base + 11'h040 + {5'h00, c}, c1);
         wr(a2, c2);
         if (r[28])
         begin
            rd(base + 11'h040 + {5'h00, c}, c1);
            rd(a2, {4'h0, c2[3:0]});
         end
         r = $urandom;
         @(negedge clock);
         {we, rq, pq, blk, col} = {3'b001, base[10:7], c};
         {area, fph, row, ctrl, mode} = r[16:0];
         {xdot, bdot, fdot} = {&r[21:20], &r[19:18], r[16] & r[17]};
         u = area && mode == 2'h0 && c1[6] && row[4:1] == 4'hB;
         fg = fdot | u;
         hide = fg && mode == 2'h0 && c1[5] && !fph;
         if (mode == 2'h3 || !area || hide || (!fg && (bdot || xdot)))
            ec = 5'h00;
         else if (fg)
            ec = mode == 2'h2 ? TBL[c1[3:1]] : {c1[1], c1[2], c1[3], mode[0] & c1[5], 1'b0};
         else
            ec = mode == 2'h2 ? TBL[c2[2:0]] : {c2[0], c2[1], c2[2], mode[0] & c2[3], 1'b0};
         n.v = {c1[0], ch, ec, area && (c1[4] || ctrl[7] || (fg && !hide)),
            area && ctrl[2] && c1[4],
            mode == 2'h0 && c1[7], {c1[0], ch} == 9'h140, c2[3], c1[7:5]};
         n.care = {2'b11, mode == 2'h2};
         notes.push_back(n);
      end
      @(negedge clock);
      pq = 1'b0;
      @(negedge clock);
      rst_n = 1'b0;
      @(negedge clock);
      rst_n = 1'b1;
      rd(a2, 8'h00);
      @(negedge clock);
      rq = 1'b0;
      @(negedge clock);
      test_done();
   end
endmodule
